/* src/irq_slice_consts.svh */
/*
  Constants of the interrupt status slice: register byte addresses, field
  positions and reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef IRQ_SLICE_CONSTS_SVH
`define IRQ_SLICE_CONSTS_SVH

// Register byte addresses on the APB side
`define STATUS_WORD_TWO_ADDR 16'hE214
`define IRQ_ENABLE_ADDR 16'hE300
`define IRQ_CLEAR_ADDR 16'hE304

// Slice field positions inside the status word
`define SLICE_HI 15
`define SLICE_LO 7
`define BIT_LINE_ERR 15
`define BIT_RX_AVAIL 14
`define BIT_THR_EMPTY 13
`define BIT_MGMT_SERIAL 12
`define BIT_SERIAL_PERIPH 11
`define BIT_AUDIO_TX 10
`define BIT_AUDIO_RX 9
`define BIT_TWO_WIRE 8
`define BIT_SECOND_TIMER 7

// Latched flags are bits 13..7; a one marks an edge-latched source
`define LATCH_EDGE_MASK 7'h41

// Reset values
`define FLAGS_RST 9'h000
`define LATCH_RST 1'b0
`define ENABLE_RST 9'h000
`define RDATA_RST 32'h0000_0000

`endif

/* src/irq_slice_pkg.sv */
/*
  Types shared by the interrupt status slice modules.
  Assumes the constants header sits beside it on the include path.
*/
package irq_slice_pkg;
  `include "irq_slice_consts.svh"

  // Nine flags of the slice, bit 15 down to bit 7
  typedef logic [8:0] slice_flags_t;
  // The seven latched flags, bit 13 down to bit 7
  typedef logic [6:0] latch_flags_t;
  typedef logic [15:0] apb_addr_t;
  typedef logic [31:0] apb_word_t;
endpackage

/* src/irq_latch_flag.sv */
/*
  One sticky request flag: set by a source level or by its rising edge,
  cleared by a one-cycle clear strobe.
  Assumes source and clear are synchronous to clk.
*/
`timescale 1ns/1ns
`include "irq_slice_consts.svh"
module irq_latch_flag
  import irq_slice_pkg::*;
#(
  parameter bit EDGE_MODE = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic src,
  input wire logic clr,
  output logic flag
);
  logic src_d_r;
  logic flag_r;
  logic set_ev;
  logic flag_nxt;

  assign set_ev = EDGE_MODE ? (src & ~src_d_r) : src;
  // Set beats clear so an event in the clearing cycle survives
  assign flag_nxt = set_ev | (flag_r & ~clr);
  assign flag = flag_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      src_d_r <= `LATCH_RST;
      flag_r <= `LATCH_RST;
    end
    else
    begin
      src_d_r <= src;
      flag_r <= flag_nxt;
    end
  end

  edge_set_a:
    assert property (@(posedge clk) disable iff (rst)
      (EDGE_MODE && src && !$past(src)) |=> flag)
    else $error("Edge flag missed its source edge");

  hold_flag_a:
    assert property (@(posedge clk) disable iff (rst)
      (flag && !clr) |=> flag)
    else $error("Flag dropped without a clear");

  clear_flag_a:
    assert property (@(posedge clk) disable iff (rst)
      (clr && !set_ev) |=> !flag)
    else $error("Flag survived a clear with no new event");
endmodule

/* src/irq_status_slice.sv */
/*
  Interrupt status slice, bits 15..7 of the second status word, with an
  enable register, a write-only clear register and one level interrupt,
  reached over an APB slave.
  Assumes all source inputs and the APB are synchronous to CLK, and that
  the UART drops its own error and timeout conditions on the read strobes.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "irq_slice_consts.svh"

// Functional notes
// - Bit 15 is OR of four UART errors
// - Bit 15 read-only, drops on status read
// - Bit 14 is data available or timeout
// - Available: buffer full, or FIFO trigger reached
// - Available clears on buffer read, FIFO drop
// - Timeout counts in FIFO mode, clears on read
// - Bit 13 sets when transmit holding empties
// - Bit 13 edge-latched, write one clears
// - Bits 12, 11: management serial, SPI flags
// - Bits 10, 9: audio transmit, receive flags
// - Bit 8: any two-wire unit condition
// - Bit 7 sets on timer 1 status
// - Bit 7 edge-latched, write one clears
// - Status word sits at offset 0xE214
module irq_status_slice
  import irq_slice_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic UART_OVERRUN,
  input wire logic UART_PARITY_ERR,
  input wire logic UART_FRAMING_ERR,
  input wire logic UART_BREAK,
  input wire logic UART_LSR_READ,
  input wire logic UART_RBR_FULL,
  input wire logic UART_FIFO_EN,
  input wire logic [4:0] UART_RX_FILL,
  input wire logic [4:0] UART_RX_TRIG,
  input wire logic UART_RX_TIMEOUT,
  input wire logic UART_RBR_READ,
  input wire logic UART_THR_EMPTY,
  input wire logic MGMT_SERIAL_REQ,
  input wire logic SERIAL_PERIPH_REQ,
  input wire logic AUDIO_TX_REQ,
  input wire logic AUDIO_RX_REQ,
  input wire logic TWO_WIRE_REQ,
  input wire logic SECOND_TIMER_REQ,
  output logic [8:0] SLICE_FLAGS,
  output logic IRQ
);
  // Flag registers
  logic line_err_r;
  logic line_err_nxt;
  logic rx_flag_r;
  logic rx_flag_nxt;
  latch_flags_t latch_flags;
  latch_flags_t latch_src;
  latch_flags_t latch_clr;
  slice_flags_t flags;

  // Software registers
  slice_flags_t enable_r;
  slice_flags_t enable_nxt;
  logic irq_r;
  logic irq_nxt;

  // APB slave state
  logic pready_r;
  logic pready_nxt;
  apb_word_t prdata_r;
  logic pslverr_r;

  // Decode
  logic apb_access;
  logic apb_done;
  logic hit_status;
  logic hit_enable;
  logic hit_clear;
  logic addr_hit;
  logic wr_done;
  logic [15:0] lane_mask;
  logic [15:0] w1c_bits;
  apb_word_t status_word;
  apb_word_t enable_word;
  apb_word_t rd_word;

  // UART line and receive conditions
  logic any_line_err;
  logic fifo_trig_hit;
  logic data_avail;
  logic timeout_part;

  // ---------------------------------------------------------------
  // UART line error, bit 15
  // ---------------------------------------------------------------
  assign any_line_err = UART_OVERRUN | UART_PARITY_ERR |
    UART_FRAMING_ERR | UART_BREAK;
  // The read mask covers the cycle before the UART itself drops the bits
  assign line_err_nxt = any_line_err & ~UART_LSR_READ;

  // ---------------------------------------------------------------
  // UART receive, bit 14
  // ---------------------------------------------------------------
  assign fifo_trig_hit = (UART_RX_FILL >= UART_RX_TRIG);
  assign data_avail = UART_FIFO_EN ? fifo_trig_hit : UART_RBR_FULL;
  // Timeout only has meaning while the FIFO runs
  assign timeout_part = UART_FIFO_EN & UART_RX_TIMEOUT;
  assign rx_flag_nxt = (data_avail | timeout_part) &
    ~UART_RBR_READ;

  // ---------------------------------------------------------------
  // Latched flags, bits 13..7
  // ---------------------------------------------------------------
  assign latch_src = {
    UART_THR_EMPTY,
    MGMT_SERIAL_REQ,
    SERIAL_PERIPH_REQ,
    AUDIO_TX_REQ,
    AUDIO_RX_REQ,
    TWO_WIRE_REQ,
    SECOND_TIMER_REQ
  };

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_latch
      irq_latch_flag #(
        .EDGE_MODE(1'((`LATCH_EDGE_MASK >> gi) & 7'h01))
      ) u_flag (
        .clk(CLK),
        .rst(SYS_RST),
        .src(latch_src[gi]),
        .clr(latch_clr[gi]),
        .flag(latch_flags[gi])
      );
    end
  endgenerate

  assign flags = {line_err_r, rx_flag_r, latch_flags};
  assign SLICE_FLAGS = flags;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign apb_access = PSEL & PENABLE;
  // Exactly one completing edge per transfer, taken on pready high
  assign apb_done = apb_access & pready_r;
  assign hit_status = (PADDR == `STATUS_WORD_TWO_ADDR);
  assign hit_enable = (PADDR == `IRQ_ENABLE_ADDR);
  assign hit_clear = (PADDR == `IRQ_CLEAR_ADDR);
  assign addr_hit = hit_status | hit_enable | hit_clear;
  assign wr_done = apb_done & PWRITE & addr_hit;
  assign lane_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  assign w1c_bits = PWDATA[15:0] & lane_mask;

  // Bits 15 and 14 never see the write data
  assign latch_clr = (wr_done & (hit_status | hit_clear)) ?
    w1c_bits[`BIT_THR_EMPTY:`SLICE_LO] : 7'h00;

  assign enable_nxt = (wr_done & hit_enable) ?
    ((enable_r & ~lane_mask[`SLICE_HI:`SLICE_LO]) |
     (PWDATA[`SLICE_HI:`SLICE_LO] & lane_mask[`SLICE_HI:`SLICE_LO])) :
    enable_r;

  assign status_word = {16'h0000, flags, 7'h00};
  assign enable_word = {16'h0000, enable_r, 7'h00};
  // Clear register is write-only and reads as zero
  assign rd_word = hit_status ? status_word :
    (hit_enable ? enable_word : `RDATA_RST);

  assign pready_nxt = apb_access & ~pready_r;
  assign irq_nxt = |(flags & enable_r);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      line_err_r <= 1'b0;
      rx_flag_r <= 1'b0;
    end
    else
    begin
      line_err_r <= line_err_nxt;
      rx_flag_r <= rx_flag_nxt;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      enable_r <= `ENABLE_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      enable_r <= enable_nxt;
      irq_r <= irq_nxt;
    end
  end

  // One wait state: pready rises on the second access cycle
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pready_r <= 1'b0;
      prdata_r <= `RDATA_RST;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= pready_nxt;
      if (pready_nxt)
      begin
        prdata_r <= PWRITE ? `RDATA_RST : rd_word;
        pslverr_r <= ~addr_hit;
      end
      else
      begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign PREADY = pready_r;
  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;
  assign IRQ = irq_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  line_err_set_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (any_line_err && !UART_LSR_READ) |=> SLICE_FLAGS[8])
    else $error("Line error flag not raised by an error condition");

  line_err_drop_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      UART_LSR_READ |=> !SLICE_FLAGS[8])
    else $error("Line error flag held across a status read");

  line_err_quiet_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      !any_line_err |=> !SLICE_FLAGS[8])
    else $error("Line error flag raised with no error present");

  rx_char_mode_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (!UART_FIFO_EN && UART_RBR_FULL && !UART_RBR_READ)
        |=> SLICE_FLAGS[7])
    else $error("Receive flag missed a full buffer");

  rx_fifo_trig_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (UART_FIFO_EN && UART_RX_FILL >= UART_RX_TRIG && !UART_RBR_READ)
        |=> SLICE_FLAGS[7])
    else $error("Receive flag missed the FIFO trigger");

  rx_below_trig_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (UART_FIFO_EN && UART_RX_FILL < UART_RX_TRIG && !UART_RX_TIMEOUT)
        |=> !SLICE_FLAGS[7])
    else $error("Receive flag held below the trigger level");

  rx_read_clear_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      UART_RBR_READ |=> !SLICE_FLAGS[7])
    else $error("Receive flag held across a buffer read");

  timeout_mode_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (!UART_FIFO_EN && !UART_RBR_FULL) |=> !SLICE_FLAGS[7])
    else $error("Timeout counted outside FIFO mode");

  timeout_set_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (UART_FIFO_EN && UART_RX_TIMEOUT && !UART_RBR_READ)
        |=> SLICE_FLAGS[7])
    else $error("Receive flag missed a character timeout");

  thr_edge_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(UART_THR_EMPTY) |=> SLICE_FLAGS[6])
    else $error("Transmit empty flag missed its edge");

  thr_w1c_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (SLICE_FLAGS[6] && wr_done && hit_status && PSTRB[1] &&
       !PWDATA[13]) |=> SLICE_FLAGS[6])
    else $error("Writing zero cleared the transmit empty flag");

  level_src_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (MGMT_SERIAL_REQ || SERIAL_PERIPH_REQ) |=>
        &(SLICE_FLAGS[5:4] | ~$past({MGMT_SERIAL_REQ, SERIAL_PERIPH_REQ})))
    else $error("Serial unit request not latched");

  audio_src_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (AUDIO_TX_REQ || AUDIO_RX_REQ) |=>
        &(SLICE_FLAGS[3:2] | ~$past({AUDIO_TX_REQ, AUDIO_RX_REQ})))
    else $error("Audio request not latched");

  two_wire_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      TWO_WIRE_REQ |=> SLICE_FLAGS[1])
    else $error("Two-wire request not latched");

  timer_clear_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (wr_done && hit_status && PSTRB[0] && PWDATA[7] &&
       !($rose(SECOND_TIMER_REQ))) |=> !SLICE_FLAGS[0])
    else $error("Timer flag survived a write of one");

  status_read_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (apb_access && !pready_r && !PWRITE && hit_status)
        |=> (PREADY && PRDATA[15:7] == $past(flags) &&
             PRDATA[31:16] == 16'h0000 && PRDATA[6:0] == 7'h00))
    else $error("Status word read returned the wrong value");

  ro_bits_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (wr_done && !any_line_err && !data_avail && !timeout_part)
        |=> (SLICE_FLAGS[8:7] == 2'b00))
    else $error("A write set a level-following flag");

  pready_pulse_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("Ready did not answer in one wait state");

  unmapped_err_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      (PSEL && PENABLE && !PREADY && !addr_hit) |=> (PREADY && PSLVERR))
    else $error("Unmapped address accepted without error");

  irq_level_a:
    assert property (@(posedge CLK) disable iff (SYS_RST)
      |(flags & enable_r) |=> IRQ)
    else $error("Interrupt low with an enabled flag set");
endmodule

/* dv/src_model.sv */
/*
  Far-side source model: UART line, receive and transmit conditions and
  the peripheral request lines that feed the status slice.
  Assumes a free-running clk; every change lands by NBA at a rising edge.
*/
`timescale 1ns/1ns
module src_model
(
  input wire logic clk,
  output logic [3:0] err,
  output logic lsr_rd,
  output logic rbr_full,
  output logic fifo_en,
  output logic [4:0] fill,
  output logic [4:0] trig,
  output logic tmo,
  output logic rbr_rd,
  output logic thr_empty,
  output logic [5:0] req
);
  initial
  begin
    {err, lsr_rd, rbr_full, fifo_en, fill, trig, tmo, rbr_rd} = '0;
    {thr_empty, req} = '0;
  end

  task automatic set_err(input logic [3:0] v);
    @(posedge clk);
    err <= v;
  endtask

  // The UART drops its own line errors when the status is read
  task automatic read_lsr();
    @(posedge clk);
    lsr_rd <= 1'b1;
    err <= 4'h0;
    @(posedge clk);
    lsr_rd <= 1'b0;
  endtask

  task automatic set_rx(input logic f, input logic e, input logic [4:0] n,
    input logic [4:0] t, input logic o);
    @(posedge clk);
    {rbr_full, fifo_en, fill, trig, tmo} <= {f, e, n, t, o};
  endtask

  // One character taken: buffer empties and any timeout ends
  task automatic read_rbr();
    @(posedge clk);
    rbr_rd <= 1'b1;
    rbr_full <= 1'b0;
    tmo <= 1'b0;
    @(posedge clk);
    rbr_rd <= 1'b0;
  endtask

  task automatic set_thr(input logic v);
    @(posedge clk);
    thr_empty <= v;
  endtask

  // Index 0 is the timer, 1..5 the requests of bits 8..12
  task automatic pulse_req(input int i);
    @(posedge clk);
    req[i] <= 1'b1;
    @(posedge clk);
    req[i] <= 1'b0;
  endtask
endmodule

/* dv/tb_top.sv */
/*
  Self-checking bench for the interrupt status slice: APB master noting
  expected answers in a queue, a monitor comparing them, source model.
  Assumes the slice answers every APB transfer within a few cycles.
*/
`timescale 1ns/1ns
`include "irq_slice_consts.svh"
module tb_top
  import irq_slice_pkg::*;
;
  localparam apb_addr_t st = `STATUS_WORD_TWO_ADDR;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [15:0] PADDR = 16'h0000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [3:0] PSTRB = 4'hF;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, IRQ;
  logic [8:0] SLICE_FLAGS;
  logic [3:0] err;
  logic lsr_rd, rbr_full, fifo_en, tmo, rbr_rd, thr_empty;
  logic [4:0] fill, trig, t;
  logic [5:0] req;
  int mismatches = 0, checked = 0, seed = 32'h6b23;
  typedef struct {logic w; logic e; logic [31:0] d;} note_s;
  note_s q[$];
  note_s note;

  always #20 CLK = ~CLK;

  irq_status_slice dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .UART_OVERRUN(err[0]), .UART_PARITY_ERR(err[1]),
    .UART_FRAMING_ERR(err[2]), .UART_BREAK(err[3]),
    .UART_LSR_READ(lsr_rd), .UART_RBR_FULL(rbr_full),
    .UART_FIFO_EN(fifo_en), .UART_RX_FILL(fill), .UART_RX_TRIG(trig),
    .UART_RX_TIMEOUT(tmo), .UART_RBR_READ(rbr_rd),
    .UART_THR_EMPTY(thr_empty), .MGMT_SERIAL_REQ(req[5]),
    .SERIAL_PERIPH_REQ(req[4]), .AUDIO_TX_REQ(req[3]),
    .AUDIO_RX_REQ(req[2]), .TWO_WIRE_REQ(req[1]),
    .SECOND_TIMER_REQ(req[0]), .SLICE_FLAGS(SLICE_FLAGS), .IRQ(IRQ));

  src_model src_u (.clk(CLK), .err(err), .lsr_rd(lsr_rd),
    .rbr_full(rbr_full), .fifo_en(fifo_en), .fill(fill), .trig(trig),
    .tmo(tmo), .rbr_rd(rbr_rd), .thr_empty(thr_empty), .req(req));

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic [31:0] x, input logic e);
    q.push_back('{w, e, x});
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, x, 1'b0);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 1'b0);
  endtask

  function automatic logic [31:0] bitv(input int b);
    return 32'h0000_0001 << b;
  endfunction

  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Answers are taken only at the edge that completes the transfer
  always @(posedge CLK)
    if (PSEL && PENABLE && PREADY === 1'b1)
    begin
      note = q.pop_front();
      check("slave error", 32'(PSLVERR), 32'(note.e));
      if (!note.w)
        check("read data", PRDATA, note.d);
    end

  initial
  begin
    repeat (5000) @(posedge CLK);
    mismatches++;
    results();
  end

  initial
  begin
    repeat (8) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(st, 32'h0000_0000);
    rd(`IRQ_ENABLE_ADDR, 32'h0000_0000);
    rd(`IRQ_CLEAR_ADDR, 32'h0000_0000);
    apb(1'b0, 16'h0100, 32'h0000_0000, 32'h0000_0000, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      src_u.set_err(4'h1 << i);
      rd(st, bitv(15));
      wr(st, bitv(15) | bitv(14));
      rd(st, bitv(15));
      src_u.read_lsr();
      rd(st, 32'h0000_0000);
    end
    $display("test line error done");
    src_u.set_rx(1'b1, 1'b0, 5'h00, 5'h1F, 1'b0);
    rd(st, bitv(14));
    src_u.read_rbr();
    rd(st, 32'h0000_0000);
    t = 5'($unsigned($random(seed)) % 31 + 1);
    src_u.set_rx(1'b0, 1'b1, t, t, 1'b0);
    rd(st, bitv(14));
    src_u.set_rx(1'b0, 1'b1, t - 5'h01, t, 1'b0);
    rd(st, 32'h0000_0000);
    src_u.set_rx(1'b0, 1'b0, 5'h00, t, 1'b1);
    rd(st, 32'h0000_0000);
    src_u.set_rx(1'b0, 1'b1, 5'h00, t, 1'b1);
    rd(st, bitv(14));
    src_u.read_rbr();
    rd(st, 32'h0000_0000);
    $display("test receive done");
    src_u.set_thr(1'b1);
    src_u.set_thr(1'b0);
    rd(st, bitv(13));
    wr(st, 32'h0000_0000);
    rd(st, bitv(13));
    @(posedge CLK);
    PSTRB <= 4'hD;
    wr(st, bitv(13));
    rd(st, bitv(13));
    @(posedge CLK);
    PSTRB <= 4'hF;
    wr(st, bitv(13));
    rd(st, 32'h0000_0000);
    $display("test transmit empty done");
    for (int i = 0; i < 6; i++)
    begin
      src_u.pulse_req(i);
      rd(st, bitv(7 + i));
      wr(st, bitv(7 + i) | ($random(seed) & 32'hFFFF_C000));
      rd(st, 32'h0000_0000);
    end
    $display("test request flags done");
    wr(`IRQ_ENABLE_ADDR, bitv(7));
    rd(`IRQ_ENABLE_ADDR, bitv(7));
    src_u.pulse_req(1);
    repeat (3) @(posedge CLK);
    check("masked irq", 32'(IRQ), 32'h0000_0000);
    src_u.pulse_req(0);
    repeat (3) @(posedge CLK);
    check("irq", 32'(IRQ), 32'h0000_0001);
    check("flags", 32'(SLICE_FLAGS), 32'h0000_0003);
    wr(`IRQ_CLEAR_ADDR, bitv(7) | bitv(8));
    repeat (3) @(posedge CLK);
    check("cleared irq", 32'(IRQ), 32'h0000_0000);
    $display("test interrupt done");
    results();
  end
endmodule
